//--- pkg/range_pkg.sv
package range_pkg;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int STEP_NS = 100;
  localparam int STEP_CYCLES = STEP_NS / CLK_PERIOD_NS;
  localparam int MAX_ERROR_NS = 500;
  localparam int MAX_ERROR_CYCLES = MAX_ERROR_NS / CLK_PERIOD_NS;
  localparam int SLOT_US = 250;
  localparam int SLOT_STEPS = SLOT_US * 1000 / STEP_NS;
  localparam int STEPS_PER_SECOND = 10000000;
  localparam int SLOTS_PER_SECOND = 4000;
  localparam int SLOT_INDEX_BITS = 6;
  localparam int OFFSET_BITS = 24;
  localparam int SLOT_BITS = 12;
  localparam int FRAC_BITS = 12;
  localparam int RANGE_INT_BITS = 6;
  localparam int RANGE_BITS = RANGE_INT_BITS + FRAC_BITS;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [OFFSET_BITS-1:0] OFFSET_RESET = 24'h000000;
  localparam logic [4:0] PRESCALE_RESET = 5'h00;
  localparam logic [RANGE_BITS-1:0] RANGE_RESET = 18'h00000;
  localparam logic [RANGE_BITS-1:0] VELOCITY_RESET = 18'h00000;
  localparam logic [3:0] ALPHA_SHIFT = 4'h2;
  localparam logic [3:0] BETA_SHIFT = 4'h4;
endpackage

//--- logic/pps_sync.sv
`timescale 1ns/1ns
module pps_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic pin,
  output logic rise
);
  // ---------------------------------------------------------------
  // Two-stage synchroniser and edge detect
  // ---------------------------------------------------------------
  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
    logic rise;
  } sync_state_t;
  sync_state_t state;
  sync_state_t next_state;

  always_comb begin
    next_state = state;
    next_state.meta = pin;
    next_state.sync = state.meta;
    next_state.last = state.sync;
    next_state.rise = state.sync & ~state.last;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign rise = state.rise;
endmodule

//--- logic/receipt_timestamp_range_measure.sv
`timescale 1ns/1ns
module receipt_timestamp_range_measure #(
  parameter int STEP_CYCLES = range_pkg::STEP_CYCLES,
  parameter int SLOT_STEPS = range_pkg::SLOT_STEPS
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic internal_receiver_fitted,
  input wire logic internal_pps,
  input wire logic external_pps,
  input wire logic transmit_request,
  input wire logic [range_pkg::SLOT_BITS-1:0] transmit_slot,
  input wire logic receive_detect,
  input wire logic state_vector_report,
  input wire logic [range_pkg::SLOT_INDEX_BITS-1:0] slot_period_index,
  input wire logic epoch_valid,
  input wire logic [range_pkg::SLOT_BITS-1:0] epoch_slot,
  input wire logic remote_utc_coupled,
  input wire logic altitude_present,
  output logic transmit_time_instant,
  output logic [range_pkg::OFFSET_BITS-1:0] receipt_time_offset,
  output logic receipt_valid,
  output logic [range_pkg::RANGE_BITS-1:0] raw_range,
  output logic [range_pkg::RANGE_BITS-1:0] filtered_range,
  output logic range_valid,
  output logic range_acquired,
  output logic validation_enable,
  output logic slant_compensation_off,
  output logic local_utc_coupled
);
  // ---------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RANGE_IDLE = 2'b00,
    RANGE_ACQUIRED = 2'b01
  } range_mode_t;

  typedef struct packed {
    logic [4:0] prescale;
    logic [range_pkg::OFFSET_BITS-1:0] offset;
    logic [range_pkg::SLOT_BITS-1:0] slot;
    logic [range_pkg::FRAC_BITS-1:0] slot_step;
    logic coupled;
    logic tx_armed;
    logic [range_pkg::SLOT_BITS-1:0] tx_slot;
    logic tx_pulse;
    logic [range_pkg::OFFSET_BITS-1:0] stamp;
    logic stamp_valid;
    range_mode_t mode;
    logic [range_pkg::RANGE_INT_BITS-1:0] int_part;
    logic [range_pkg::RANGE_BITS-1:0] raw;
    logic [range_pkg::RANGE_BITS-1:0] est;
    logic [range_pkg::RANGE_BITS-1:0] vel;
    logic [range_pkg::SLOT_BITS-1:0] last_slot;
    logic have_sample;
    logic rng_valid;
    logic validate;
    logic no_altitude;
    logic acquired;
  } core_state_t;

  core_state_t state;
  core_state_t next_state;
  logic int_rise;
  logic ext_rise;

  // ---------------------------------------------------------------
  // Reference pulse synchronisers
  // ---------------------------------------------------------------
  pps_sync int_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(internal_pps),
    .rise(int_rise)
  );

  pps_sync ext_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .pin(external_pps),
    .rise(ext_rise)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [range_pkg::RANGE_BITS-1:0] shift_down(
    input logic [range_pkg::RANGE_BITS-1:0] value,
    input logic [3:0] amount
  );
    logic signed [range_pkg::RANGE_BITS-1:0] s;
    s = value;
    return range_pkg::RANGE_BITS'(s >>> amount);
  endfunction

  function automatic logic [range_pkg::FRAC_BITS-1:0] slot_frac(
    input logic [range_pkg::FRAC_BITS-1:0] rx_step
  );
    return rx_step;
  endfunction

  function automatic logic [range_pkg::SLOT_BITS-1:0] slot_diff(
    input logic [range_pkg::SLOT_BITS-1:0] later,
    input logic [range_pkg::SLOT_BITS-1:0] earlier
  );
    return later - earlier;
  endfunction

  function automatic logic [range_pkg::RANGE_INT_BITS-1:0] whole_slots(
    input logic [range_pkg::SLOT_BITS-1:0] elapsed
  );
    return elapsed[range_pkg::RANGE_INT_BITS-1:0];
  endfunction

  function automatic logic last_step_of_slot(
    input logic [range_pkg::FRAC_BITS-1:0] step
  );
    return step == range_pkg::FRAC_BITS'(SLOT_STEPS - 1);
  endfunction

  function automatic logic at_slot_start(
    input logic [4:0] prescale,
    input logic [range_pkg::FRAC_BITS-1:0] step
  );
    return prescale == range_pkg::PRESCALE_RESET && step == '0;
  endfunction

  function automatic logic second_overrun(
    input logic [range_pkg::OFFSET_BITS-1:0] offset
  );
    return offset == range_pkg::OFFSET_BITS'(range_pkg::STEPS_PER_SECOND + 1);
  endfunction

  function automatic logic [range_pkg::RANGE_BITS-1:0] predict(
    input logic [range_pkg::RANGE_BITS-1:0] est,
    input logic [range_pkg::RANGE_BITS-1:0] vel,
    input logic [range_pkg::SLOT_BITS-1:0] slots
  );
    logic [range_pkg::RANGE_BITS+range_pkg::SLOT_BITS-1:0] travel;
    travel = vel * slots;
    return est + travel[range_pkg::RANGE_BITS-1:0];
  endfunction

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  logic second_edge;
  logic step_tick;
  logic [range_pkg::RANGE_INT_BITS-1:0] whole;
  logic [range_pkg::RANGE_BITS-1:0] sample;
  logic [range_pkg::RANGE_BITS-1:0] predicted;
  logic [range_pkg::RANGE_BITS-1:0] residual;
  logic [range_pkg::SLOT_BITS-1:0] gap;
  logic fire;

  always_comb begin
    next_state = state;
    whole = '0;
    sample = '0;
    predicted = '0;
    residual = '0;
    gap = '0;
    fire = 1'b0;
    // ---------------------------------------------------------------
    // Reference selection
    // ---------------------------------------------------------------
    second_edge = internal_receiver_fitted ? int_rise : ext_rise;
    step_tick = (state.prescale == 5'(STEP_CYCLES - 1));
    next_state.tx_pulse = 1'b0;
    next_state.stamp_valid = 1'b0;

    // ---------------------------------------------------------------
    // Timebase
    // ---------------------------------------------------------------
    if (second_edge) begin
      next_state.prescale = range_pkg::PRESCALE_RESET;
      next_state.offset = range_pkg::OFFSET_RESET;
      next_state.slot = '0;
      next_state.slot_step = '0;
      next_state.coupled = 1'b1;
    end else if (step_tick) begin
      next_state.prescale = range_pkg::PRESCALE_RESET;
      next_state.offset = state.offset + 1'b1;
      if (last_step_of_slot(state.slot_step)) begin
        next_state.slot_step = '0;
        next_state.slot = state.slot + 1'b1;
      end else begin
        next_state.slot_step = state.slot_step + 1'b1;
      end
    end else begin
      next_state.prescale = state.prescale + 1'b1;
    end

    // ---------------------------------------------------------------
    // Coupling lost after a missed second
    // ---------------------------------------------------------------
    if (!second_edge && step_tick && second_overrun(state.offset)) begin
      next_state.coupled = 1'b0;
    end

    // ---------------------------------------------------------------
    // Transmit on the slot boundary
    // ---------------------------------------------------------------
    if (transmit_request) begin
      next_state.tx_armed = 1'b1;
      next_state.tx_slot = transmit_slot;
    end
    fire = state.tx_armed && state.slot == state.tx_slot
           && at_slot_start(state.prescale, state.slot_step);
    if (fire) begin
      next_state.tx_pulse = 1'b1;
      next_state.tx_armed = transmit_request;
    end

    // ---------------------------------------------------------------
    // Receipt stamp
    // ---------------------------------------------------------------
    if (receive_detect) begin
      next_state.stamp = state.offset;
      next_state.stamp_valid = 1'b1;
    end

    // ---------------------------------------------------------------
    // Range on each state report
    // ---------------------------------------------------------------
    if (receive_detect && state_vector_report) begin
      whole = whole_slots(slot_diff(state.slot,
                                    range_pkg::SLOT_BITS'(slot_period_index)));
      if (epoch_valid) begin
        whole = whole_slots(slot_diff(state.slot, epoch_slot));
        next_state.int_part = whole;
        next_state.mode = RANGE_ACQUIRED;
        next_state.acquired = 1'b1;
      end else begin
        whole = state.int_part;
      end
      sample = {whole, slot_frac(state.slot_step)};
      next_state.raw = sample;
      // -------------------------------------------------------------
      // Range filter
      // -------------------------------------------------------------
      if (epoch_valid || state.mode == RANGE_ACQUIRED) begin
        gap = slot_diff(state.slot, state.last_slot);
        next_state.last_slot = state.slot;
        if (!state.have_sample || epoch_valid) begin
          next_state.est = sample;
          next_state.vel = range_pkg::VELOCITY_RESET;
          next_state.have_sample = 1'b1;
        end else begin
          // Prediction scaled by the elapsed slots
          predicted = predict(state.est, state.vel, gap);
          residual = sample - predicted;
          next_state.est = predicted + shift_down(residual, range_pkg::ALPHA_SHIFT);
          if (gap != '0) begin
            next_state.vel = state.vel + shift_down(residual, range_pkg::BETA_SHIFT);
          end
        end
        next_state.rng_valid = 1'b1;
        next_state.no_altitude = !altitude_present;
      end
    end

    // ---------------------------------------------------------------
    // Validation gate
    // ---------------------------------------------------------------
    next_state.validate = state.coupled && remote_utc_coupled
                          && state.mode == RANGE_ACQUIRED;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= '0;
      state.mode <= RANGE_IDLE;
      state.raw <= range_pkg::RANGE_RESET;
      state.est <= range_pkg::RANGE_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign transmit_time_instant = state.tx_pulse;
  assign receipt_time_offset = state.stamp;
  assign receipt_valid = state.stamp_valid;
  assign raw_range = state.raw;
  assign filtered_range = state.est;
  assign range_valid = state.rng_valid;
  assign range_acquired = state.acquired;
  assign validation_enable = state.validate;
  assign slant_compensation_off = state.no_altitude;
  assign local_utc_coupled = state.coupled;
endmodule

//--- bench/range_props.sv
`timescale 1ns/1ns
module range_props #(
  parameter int STEP_CYCLES = 25,
  parameter int SLOT_STEPS = 2500
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic receive_detect,
  input wire logic state_vector_report,
  input wire logic epoch_valid,
  input wire logic [range_pkg::SLOT_BITS-1:0] epoch_slot,
  input wire logic remote_utc_coupled,
  input wire logic transmit_time_instant,
  input wire logic [range_pkg::OFFSET_BITS-1:0] receipt_time_offset,
  input wire logic receipt_valid,
  input wire logic [range_pkg::RANGE_BITS-1:0] raw_range,
  input wire logic range_acquired,
  input wire logic validation_enable
);
  logic [5:0] int_part;
  assign int_part = raw_range[17:12];
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_stamp_answer: assert property (receive_detect |=> receipt_valid)
    else $error("receipt pulse missing");
  chk_stamp_cause: assert property (receipt_valid |-> $past(receive_detect))
    else $error("receipt pulse without arrival");
  chk_stamp_hold: assert property (!receipt_valid |-> $stable(receipt_time_offset))
    else $error("stamp changed without receipt");
  chk_frac_part: assert property (receipt_valid && $past(state_vector_report) && range_acquired
    |-> raw_range[11:0] == 12'(receipt_time_offset % SLOT_STEPS))
    else $error("fraction part wrong");
  chk_int_part: assert property (receipt_valid && $past(state_vector_report && epoch_valid)
    |-> int_part == 6'((receipt_time_offset / SLOT_STEPS) - $past(epoch_slot)))
    else $error("integer part wrong");
  chk_int_held: assert property (receipt_valid
    && $past(state_vector_report && !epoch_valid && range_acquired)
    |-> int_part == $past(int_part))
    else $error("integer part moved without epoch");
  chk_acquire_cause: assert property ($rose(range_acquired)
    |-> $past(receive_detect && state_vector_report && epoch_valid))
    else $error("acquired without epoch report");
  chk_validate_gate: assert property ((!remote_utc_coupled)[*3] |=> !validation_enable)
    else $error("validation while remote uncoupled");
  chk_tx_pulse: assert property (transmit_time_instant |=> !transmit_time_instant)
    else $error("transmit pulse too long");
endmodule
bind receipt_timestamp_range_measure range_props #(
  .STEP_CYCLES(STEP_CYCLES),
  .SLOT_STEPS(SLOT_STEPS)
) i_range_props (.mclk, .reset_n, .receive_detect, .state_vector_report, .epoch_valid,
  .epoch_slot, .remote_utc_coupled, .transmit_time_instant, .receipt_time_offset,
  .receipt_valid, .raw_range, .range_acquired, .validation_enable);

//--- bench/remote_participant.sv
`timescale 1ns/1ns
module remote_participant (
  input wire logic mclk,
  output logic receive_detect,
  output logic state_vector_report,
  output logic [5:0] slot_period_index,
  output logic epoch_valid,
  output logic [11:0] epoch_slot,
  output logic remote_utc_coupled,
  output logic altitude_present
);
  initial begin
    {receive_detect, state_vector_report, epoch_valid, altitude_present} = 4'h0;
    {slot_period_index, epoch_slot} = 18'h00000;
    remote_utc_coupled = 1'b0;
  end
  task automatic announce(input logic c);
    remote_utc_coupled = c;
  endtask
  task automatic send(input int gap, input logic sv, input logic ep, input logic [11:0] slot,
    input logic alt);
    repeat (gap) @(negedge mclk);
    receive_detect = 1'b1;
    state_vector_report = sv;
    epoch_valid = ep;
    epoch_slot = slot;
    slot_period_index = slot[5:0];
    altitude_present = alt;
    @(negedge mclk);
    {receive_detect, state_vector_report, epoch_valid} = 3'h0;
    epoch_slot = ~slot;
    slot_period_index = ~slot[5:0];
  endtask
endmodule

//--- bench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int P_STEP = 25;
  localparam int P_SLOT = 4;
  localparam int TOL = range_pkg::MAX_ERROR_CYCLES;
  logic mclk = 0, reset_n = 0, internal_receiver_fitted = 0, internal_pps = 0, external_pps = 0;
  logic transmit_request = 0, receive_detect, state_vector_report, epoch_valid;
  logic remote_utc_coupled, altitude_present, transmit_time_instant, receipt_valid;
  logic range_valid, range_acquired, validation_enable, slant_compensation_off;
  logic local_utc_coupled;
  logic [11:0] transmit_slot = 0, epoch_slot;
  logic [5:0] slot_period_index;
  logic [23:0] receipt_time_offset;
  logic [17:0] raw_range, filtered_range;
  int errors = 0, cmp_count = 0, seed = 74861, cyc = 0, pps_cyc = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  remote_participant i_remote_participant (.mclk, .receive_detect, .state_vector_report,
    .slot_period_index, .epoch_valid, .epoch_slot, .remote_utc_coupled, .altitude_present);
  receipt_timestamp_range_measure #(.STEP_CYCLES(P_STEP), .SLOT_STEPS(P_SLOT))
    i_receipt_timestamp_range_measure (.mclk, .reset_n, .internal_receiver_fitted,
    .internal_pps, .external_pps, .transmit_request, .transmit_slot, .receive_detect,
    .state_vector_report, .slot_period_index, .epoch_valid, .epoch_slot, .remote_utc_coupled,
    .altitude_present, .transmit_time_instant, .receipt_time_offset, .receipt_valid,
    .raw_range, .filtered_range, .range_valid, .range_acquired, .validation_enable,
    .slant_compensation_off, .local_utc_coupled);
  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] expd);
    cmp_count++;
    if (seen !== expd) begin
      errors++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, expd);
    end
  endtask
  function automatic logic near(input int a, input int b, input int tol);
    return (a - b <= tol) && (b - a <= tol);
  endfunction
  task end_sim;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task pulse_pps(input logic sel);
    if (sel) internal_pps = 1'b1;
    else external_pps = 1'b1;
    repeat (4) @(negedge mclk);
    {internal_pps, external_pps} = 2'h0;
  endtask
  task receive(input logic sv, input logic ep, input logic alt, input int gap);
    int n;
    i_remote_participant.send(gap, sv, ep, 12'($random(seed)), alt);
    n = cyc;
    for (int k = 0; k < 4 && receipt_valid !== 1'b1; k++) @(negedge mclk);
    check(receipt_valid, 1);
    check(near(receipt_time_offset, (n - pps_cyc) / P_STEP, TOL / P_STEP), 1);
    @(negedge mclk);
    if (sv && !alt) check(slant_compensation_off, 1);
  endtask
  task transmit;
    int k;
    k = (cyc - pps_cyc) / (P_STEP * P_SLOT) + 2;
    transmit_slot = 12'(k);
    transmit_request = 1'b1;
    @(negedge mclk);
    transmit_request = 1'b0;
    for (int n = 0; n < 4 * P_STEP * P_SLOT && transmit_time_instant !== 1'b1; n++)
      @(negedge mclk);
    check(near(cyc, pps_cyc + k * P_STEP * P_SLOT, TOL), 1);
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    for (int src = 0; src < 2; src++) begin
      reset_n = 1'b0;
      internal_receiver_fitted = src[0];
      repeat (5) @(negedge mclk);
      reset_n = 1'b1;
      @(negedge mclk);
      check(receipt_time_offset, 0);
      check(range_valid, 0);
      check(local_utc_coupled, 0);
      pps_cyc = cyc;
      pulse_pps(src[0]);
      check(local_utc_coupled, 1);
      i_remote_participant.announce(1'b0);
      receive(1'b1, 1'b0, 1'b1, 50);
      check(range_acquired, 0);
      receive(1'b1, 1'b1, 1'b1, 1 + ($random(seed) & 255));
      check(range_acquired, 1);
      check(filtered_range, raw_range);
      repeat (3) @(negedge mclk);
      check(validation_enable, 0);
      i_remote_participant.announce(1'b1);
      receive(1'b1, 1'b1, 1'b0, 7);
      repeat (3) @(negedge mclk);
      check(validation_enable, 1);
      for (int i = 0; i < 10; i++) begin
        receive(1'b1, 1'($random(seed)), 1'($random(seed)), i == 3 ? 0 : $random(seed) & 511);
        check(range_valid, 1);
      end
      transmit;
      pulse_pps(~src[0]);
      receive(1'b0, 1'b0, 1'b1, 20);
      transmit;
    end
    end_sim;
  end
  initial begin
    #200000;
    errors++;
    end_sim;
  end
endmodule
